// ### hw/hrx_cdr_top.sv
// Three-lane receive port with lock routing, calibration status and clock plan registers.
//
// How it works
// - analog reset holds lane recovery, deserializer.
// - digital reset holds lane parallel datapath.
// - data-lock request ignored; reference request picks mode.
// - locked status follows the active lock mode.
// - parallel data is ten bits, lanes, symbols.
// - calibration busy at start and reconfig reset.
// - reconfig request 210 bits, response 138 bits.
// - high rates: TMDS clock is rate/40.
// - high rates: reference clock is 4x TMDS.
// - low rates: TMDS clock is rate/10.
// - low rates: reference clock equals TMDS clock.
// - below minimum link rate, oversample by five.
// - oversampling: reference clock is 5x TMDS.
// - plan gives reference, link and video clocks.
// - transmit side uses the same plan.
// - video clock scales by eight over component bits.
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
module hrx_cdr_top import hrx_pkg::*; #(
	parameter int SPC = 2
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic link_clk,
	input wire logic [LANES-1:0] analog_rst,
	input wire logic [LANES-1:0] digital_rst,
	input wire logic [LANES-1:0] lock_ref_req,
	input wire logic [LANES-1:0] data_lock_req,
	input wire logic [LANES-1:0] serial_in,
	input wire logic reconfig_rst,
	input wire logic [RCFG_REQ_W-1:0] reconfig_request_bus,
	output logic [RCFG_RSP_W-1:0] reconfig_response_bus,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [DATA_W-1:0] rd_data,
	output logic [SPC*LANES*SYM_W-1:0] parallel_data,
	output logic [LANES-1:0] cdr_reference_locked,
	output logic [LANES-1:0] cdr_data_locked,
	output logic [LANES-1:0] cal_busy,
	output logic oversample_req
);
	localparam int WORD_W = SPC * SYM_W;
	localparam int SPC_SHIFT = (SPC == 4) ? 2 : (SPC == 2) ? 1 : 0;
	localparam logic [CAL_CNT_W-1:0] CAL_LOAD = CAL_CNT_W'(CAL_CYCLES);

	generate
		if (!(SPC == 1 || SPC == 2 || SPC == 4)) begin : g_bad_spc
			$error("symbols per clock must be 1, 2 or 4");
		end
	endgenerate

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	hrx_bpc_e bpc_r;
	logic [RATE_W-1:0] bit_rate_r, min_link_r;
	hrx_plan_s plan_r;
	logic plan_vld_r;
	logic [LANES-1:0] dlr_r, cal_busy_r;
	logic [CAL_CNT_W-1:0] cal_cnt_r;
	logic [2*LANES-1:0] stat_s1_r, stat_s2_r;
	logic [DATA_W-1:0] rd_data_r;
	logic [RCFG_RSP_W-1:0] rsp_r;
	logic [LANES-1:0] lane_ref_w, lane_data_w;

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	wire wr_ctrl_w = wr_en && addr == REG_CTRL;
	wire wr_rate_w = wr_en && addr == REG_BIT_RATE;
	wire wr_min_w = wr_en && addr == REG_MIN_LINK;
	wire wr_lane_w = wr_en && addr == REG_LANE;
	wire rcfg_wr_w = reconfig_request_bus[RCFG_WR_BIT];
	wire [RATE_W-1:0] rcfg_rate_w = reconfig_request_bus[RATE_W-1:0];
	wire [RATE_W-1:0] bit_rate_nxt = wr_rate_w ? wr_data[RATE_W-1:0] :
		rcfg_wr_w ? rcfg_rate_w : bit_rate_r;
	wire [RATE_W-1:0] min_link_nxt = wr_min_w ? wr_data[RATE_W-1:0] : min_link_r;
	wire [LANES-1:0] dlr_clr_w = wr_lane_w ? wr_data[LANE_DLR_LSB +: LANES] : '0;
	// A stray data-lock request is only recorded; setting wins over clearing.
	wire [LANES-1:0] dlr_nxt = data_lock_req | (dlr_r & ~dlr_clr_w);

	// ----------------------------------------------------------------
	// Clock plan
	// ----------------------------------------------------------------
	wire high_w = bit_rate_r >= HIGH_RATE_KBPS;
	wire os_w = bit_rate_r < min_link_r;
	wire oor_w = bit_rate_r > MAX_RATE_KBPS;
	wire [RATE_W-1:0] tmds_w = high_w ? bit_rate_r / TMDS_DIV_HIGH :
		bit_rate_r / TMDS_DIV_LOW;
	wire [RATE_W-1:0] ref_w = os_w ? tmds_w * REF_MULT_OS :
		high_w ? tmds_w * REF_MULT_HIGH :
		tmds_w;
	wire [RATE_W-1:0] link_w = (bit_rate_r / LINK_DIV) >> SPC_SHIFT;
	// Deep colour: the link carries more bits per pixel, so video runs slower.
	wire [RATE_W-1:0] video_w = (bpc_r == HRX_BPC_10) ? link_w * 24'h4 / 24'h5 :
		(bpc_r == HRX_BPC_12) ? link_w * 24'h2 / 24'h3 :
		(bpc_r == HRX_BPC_16) ? link_w >> 1 : link_w;
	// The same plan serves a transmit port, so no direction field exists.
	wire hrx_plan_s plan_w = {high_w, os_w, oor_w, tmds_w, ref_w, link_w, video_w};

	// ----------------------------------------------------------------
	// Calibration
	// ----------------------------------------------------------------
	wire [CAL_CNT_W-1:0] cal_nxt = reconfig_rst ? CAL_LOAD :
		(cal_cnt_r != '0) ? cal_cnt_r - 1'b1 : '0;
	wire cal_busy_nxt = cal_nxt != '0;

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	wire [DATA_W-1:0] plan_word_w = {28'h0, plan_vld_r, plan_r.oor, plan_r.os, plan_r.high};
	wire [DATA_W-1:0] lane_word_w = {17'h0, dlr_r, lock_ref_req, cal_busy_r,
		stat_s2_r[2*LANES-1:LANES], stat_s2_r[LANES-1:0]};
	wire [DATA_W-1:0] rd_mux_w = (addr == REG_CTRL) ? {30'h0, bpc_r} :
		(addr == REG_BIT_RATE) ? {8'h0, bit_rate_r} :
		(addr == REG_MIN_LINK) ? {8'h0, min_link_r} :
		(addr == REG_PLAN) ? plan_word_w :
		(addr == REG_TMDS) ? {8'h0, plan_r.tmds} :
		(addr == REG_REFCLK) ? {8'h0, plan_r.refclk} :
		(addr == REG_LINK) ? {8'h0, plan_r.link} :
		(addr == REG_VIDEO) ? {8'h0, plan_r.video} :
		(addr == REG_LANE) ? lane_word_w : 32'h0;
	wire [RCFG_RSP_W-1:0] rsp_nxt = RCFG_RSP_W'({stat_s2_r[2*LANES-1:LANES],
		stat_s2_r[LANES-1:0], cal_busy_r});

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bpc_r <= HRX_BPC_8;
			bit_rate_r <= BIT_RATE_RST;
			min_link_r <= MIN_LINK_RST;
			dlr_r <= '0;
		end else begin
			bpc_r <= wr_ctrl_w ? hrx_bpc_e'(wr_data[1:0]) : bpc_r;
			bit_rate_r <= bit_rate_nxt;
			min_link_r <= min_link_nxt;
			dlr_r <= dlr_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			plan_r <= '0;
			plan_vld_r <= 1'b0;
		end else begin
			plan_r <= plan_w;
			plan_vld_r <= 1'b1;
		end
	end

	// Calibration starts busy out of reset, so the reset controller waits.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cal_cnt_r <= CAL_LOAD;
			cal_busy_r <= {LANES{1'b1}};
		end else begin
			cal_cnt_r <= cal_nxt;
			cal_busy_r <= {LANES{cal_busy_nxt}};
		end
	end

	// Lock status crosses from the link clock; only the second stage is read.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stat_s1_r <= '0;
			stat_s2_r <= '0;
		end else begin
			stat_s1_r <= {lane_data_w, lane_ref_w};
			stat_s2_r <= stat_s1_r;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_r <= '0;
			rsp_r <= '0;
		end else begin
			rd_data_r <= rd_en ? rd_mux_w : '0;
			rsp_r <= rsp_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Lanes
	// ----------------------------------------------------------------
	generate
		for (genvar i = 0; i < LANES; i++) begin : g_lane
			hrx_lane #(.SPC(SPC)) u_lane (
				.link_clk(link_clk),
				.analog_rst(analog_rst[i]),
				.digital_rst(digital_rst[i]),
				.lock_ref_req(lock_ref_req[i]),
				.oversample(plan_r.os),
				.serial_in(serial_in[i]),
				.word(parallel_data[i*WORD_W +: WORD_W]),
				.locked_ref(lane_ref_w[i]),
				.locked_data(lane_data_w[i])
			);
		end
	endgenerate

	assign cdr_reference_locked = lane_ref_w;
	assign cdr_data_locked = lane_data_w;
	assign cal_busy = cal_busy_r;
	assign rd_data = rd_data_r;
	assign reconfig_response_bus = rsp_r;
	// The controller turns this into the per-lane reference request.
	assign oversample_req = plan_r.os;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_tmds_high: assert property (plan_vld_r && plan_r.high |->
		plan_r.tmds == $past(bit_rate_r) / TMDS_DIV_HIGH)
		else $error("high range TMDS clock wrong");
	a_tmds_low: assert property (plan_vld_r && !plan_r.high |->
		plan_r.tmds == $past(bit_rate_r) / TMDS_DIV_LOW)
		else $error("low range TMDS clock wrong");
	a_ref_high: assert property (plan_r.high && !plan_r.os |->
		plan_r.refclk == plan_r.tmds * REF_MULT_HIGH)
		else $error("high range reference clock wrong");
	a_ref_low: assert property (plan_vld_r && !plan_r.high && !plan_r.os |->
		plan_r.refclk == plan_r.tmds)
		else $error("low range reference clock wrong");
	a_ref_oversample: assert property (plan_r.os |->
		plan_r.refclk == plan_r.tmds * REF_MULT_OS)
		else $error("oversampled reference clock wrong");
	a_os_choice: assert property (plan_vld_r |->
		plan_r.os == ($past(bit_rate_r) < $past(min_link_r)))
		else $error("oversampling choice wrong");
	a_video_deep: assert property (plan_vld_r && $past(bpc_r) == HRX_BPC_16 |->
		plan_r.video == (plan_r.link >> 1))
		else $error("deep colour video clock wrong");
	a_cal_reconfig: assert property ($fell(reconfig_rst) |->
		(cal_busy_r == 3'h7) [*8])
		else $error("calibration busy dropped after reconfig reset");
	a_cal_ends: assert property (cal_cnt_r == 1 && !reconfig_rst |=> cal_busy_r == 3'h0)
		else $error("calibration busy did not end");
	a_rsp_status: assert property (plan_vld_r |->
		rsp_r[RSP_CAL_LSB +: LANES] == $past(cal_busy_r))
		else $error("response bus status stale");
	a_read_idle: assert property (!$past(rd_en) |-> rd_data_r == 32'h0)
		else $error("read data outside read slot");

	c_oversample: cover property (plan_r.os && !plan_r.high);
	c_high_rate: cover property (plan_r.high && !plan_r.os);
	c_cal_done: cover property ($fell(cal_busy_r[0]));
	c_lane_read: cover property (rd_en && addr == REG_LANE ##1 rd_data_r[0]);
endmodule // hrx_cdr_top

// ### hw/hrx_lane.sv
// One receive lane: clock recovery lock model and deserializer on the link clock.
`timescale 1ns/1ps
module hrx_lane import hrx_pkg::*; #(
	parameter int SPC = 2
) (
	input wire logic link_clk,
	input wire logic analog_rst,
	input wire logic digital_rst,
	input wire logic lock_ref_req,
	input wire logic oversample,
	input wire logic serial_in,
	output logic [SPC*SYM_W-1:0] word,
	output logic locked_ref,
	output logic locked_data
);
	localparam int WORD_W = SPC * SYM_W;
	localparam int BC_W = $clog2(WORD_W);
	localparam logic [BC_W-1:0] BIT_LAST = BC_W'(WORD_W - 1);

	generate
		if (SPC < 1) begin : g_bad_spc
			$error("symbols per clock must be at least 1");
		end
	endgenerate
	// ----------------------------------------------------------------
	// Synchronisers and sample pacing
	// ----------------------------------------------------------------
	logic [2:0] s1_r, s2_r;
	logic [2:0] os_cnt_r;
	logic prev_r, mode_r, full_r, locked_ref_r, locked_data_r;
	logic [6:0] cnt_r;
	logic [BC_W-1:0] bit_r;
	logic [WORD_W-1:0] sh_r, word_r;
	hrx_cdr_e state_r, state_nxt;
	wire ser_w = s2_r[2];
	wire ref_mode_w = s2_r[1];
	wire os_w = s2_r[0];
	wire take_w = !os_w || os_cnt_r == 3'h0;
	wire [2:0] os_nxt = (!os_w || os_cnt_r == OS_LAST) ? 3'h0 : os_cnt_r + 3'h1;
	wire edge_w = take_w && ser_w != prev_r;
	wire mode_chg_w = ref_mode_w != mode_r;
	wire done_w = mode_r ? cnt_r == LOCK_REF_LAST : (cnt_r == LOCK_DATA_LAST && edge_w);
	wire [6:0] cnt_nxt = (state_r == CDR_ACQ && (mode_r || edge_w)) ? cnt_r + 7'h1 :
		(state_r == CDR_ACQ) ? cnt_r : 7'h0;
	wire shift_w = take_w && state_r == CDR_LOCK;
	// ----------------------------------------------------------------
	// Lock state
	// ----------------------------------------------------------------
	always_comb begin
		case (state_r)
			CDR_HOLD: state_nxt = CDR_ACQ;
			CDR_ACQ: state_nxt = mode_chg_w ? CDR_HOLD : done_w ? CDR_LOCK : CDR_ACQ;
			CDR_LOCK: state_nxt = mode_chg_w ? CDR_HOLD : CDR_LOCK;
			default: state_nxt = CDR_HOLD;
		endcase
	end
	// Analog reset holds recovery and deserializer.
	always_ff @(posedge link_clk or posedge analog_rst) begin
		if (analog_rst) begin
			s1_r <= 3'h0;
			s2_r <= 3'h0;
			os_cnt_r <= 3'h0;
			prev_r <= 1'b0;
			mode_r <= 1'b0;
			state_r <= CDR_HOLD;
			cnt_r <= 7'h0;
			locked_ref_r <= 1'b0;
			locked_data_r <= 1'b0;
			bit_r <= '0;
			sh_r <= '0;
			full_r <= 1'b0;
		end else begin
			s1_r <= {serial_in, lock_ref_req, oversample};
			s2_r <= s1_r;
			os_cnt_r <= os_nxt;
			prev_r <= take_w ? ser_w : prev_r;
			mode_r <= (state_r == CDR_HOLD) ? ref_mode_w : mode_r;
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			locked_ref_r <= state_nxt == CDR_LOCK && mode_r;
			locked_data_r <= state_nxt == CDR_LOCK && !mode_r;
			bit_r <= shift_w ? ((bit_r == BIT_LAST) ? '0 : bit_r + 1'b1) : bit_r;
			sh_r <= shift_w ? {ser_w, sh_r[WORD_W-1:1]} : sh_r;
			full_r <= shift_w && bit_r == BIT_LAST;
		end
	end
	// Digital reset clears only the parallel word.
	always_ff @(posedge link_clk or posedge digital_rst) begin
		if (digital_rst) begin
			word_r <= '0;
		end else if (full_r) begin
			word_r <= sh_r;
		end
	end
	assign word = word_r;
	assign locked_ref = locked_ref_r;
	assign locked_data = locked_data_r;
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge link_clk); endclocking
	default disable iff (analog_rst);
	a_lock_mode_excl: assert property (locked_data_r |-> !mode_r && !locked_ref_r)
		else $error("data lock shown in reference mode");
	a_word_load: assert property (full_r && !digital_rst |=> digital_rst || word_r == $past(sh_r))
		else $error("parallel word not loaded");
	a_digital_hold: assert property (digital_rst |-> word_r == '0)
		else $error("word not held in digital reset");
	a_relock_mode: assert property (state_r == CDR_LOCK && mode_chg_w |=> !locked_ref_r && !locked_data_r)
		else $error("lock kept across mode change");
endmodule // hrx_lane

// ### include/hrx_pkg.sv
// Shared constants, types and register map of the receive lane and clock plan block.
package hrx_pkg;
	// ----------------------------------------------------------------
	// Structure
	// ----------------------------------------------------------------
	localparam int LANES = 3;
	localparam int SYM_W = 10;
	localparam int RCFG_REQ_W = 210;
	localparam int RCFG_RSP_W = 138;
	localparam int RCFG_WR_BIT = 209;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int RATE_W = 24;
	// ----------------------------------------------------------------
	// Register map and fields
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_BIT_RATE = 4'h1;
	localparam logic [3:0] REG_MIN_LINK = 4'h2;
	localparam logic [3:0] REG_PLAN = 4'h3;
	localparam logic [3:0] REG_TMDS = 4'h4;
	localparam logic [3:0] REG_REFCLK = 4'h5;
	localparam logic [3:0] REG_LINK = 4'h6;
	localparam logic [3:0] REG_VIDEO = 4'h7;
	localparam logic [3:0] REG_LANE = 4'h8;
	localparam int LANE_REF_LSB = 0;
	localparam int LANE_DATA_LSB = 3;
	localparam int LANE_CAL_LSB = 6;
	localparam int LANE_REQ_LSB = 9;
	localparam int LANE_DLR_LSB = 12;
	localparam int RSP_CAL_LSB = 0;
	localparam int RSP_REF_LSB = 3;
	localparam int RSP_DATA_LSB = 6;
	localparam logic [23:0] BIT_RATE_RST = 24'h5b8d80;
	localparam logic [23:0] MIN_LINK_RST = 24'h0952b8;
	// ----------------------------------------------------------------
	// Clock plan figures, rates in kbit/s and clocks in kHz
	// ----------------------------------------------------------------
	localparam logic [23:0] HIGH_RATE_KBPS = 24'h33e140;
	localparam logic [23:0] MAX_RATE_KBPS = 24'h5b8d80;
	localparam logic [23:0] TMDS_DIV_HIGH = 24'h28;
	localparam logic [23:0] TMDS_DIV_LOW = 24'h0a;
	localparam logic [23:0] REF_MULT_HIGH = 24'h4;
	localparam logic [23:0] REF_MULT_OS = 24'h5;
	localparam logic [23:0] LINK_DIV = 24'h0a;
	localparam logic [2:0] OS_LAST = 3'h4;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int CAL_TIME_NS = 10000;
	localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CAL_CNT_W = $clog2(CAL_CYCLES + 1);
	localparam logic [6:0] LOCK_REF_LAST = 7'h3f;
	localparam logic [6:0] LOCK_DATA_LAST = 7'h0f;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		HRX_BPC_8 = 2'h0,
		HRX_BPC_10 = 2'h1,
		HRX_BPC_12 = 2'h2,
		HRX_BPC_16 = 2'h3
	} hrx_bpc_e;
	typedef enum logic [2:0] {
		CDR_HOLD = 3'b001,
		CDR_ACQ = 3'b010,
		CDR_LOCK = 3'b100
	} hrx_cdr_e;
	typedef struct packed {
		logic high;
		logic os;
		logic oor;
		logic [23:0] tmds;
		logic [23:0] refclk;
		logic [23:0] link;
		logic [23:0] video;
	} hrx_plan_s;
endpackage

// ### testbench/hrx_ctl_model.sv
// Model of the lane reset sequencer and reconfiguration controller around the receive port.
`timescale 1ns/1ps
module hrx_ctl_model import hrx_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic os_need,
	input wire logic [LANES-1:0] cal_busy,
	input wire logic [LANES-1:0] ref_locked,
	input wire logic [LANES-1:0] data_locked,
	output logic [LANES-1:0] analog_rst,
	output logic [LANES-1:0] digital_rst,
	output logic [LANES-1:0] lock_ref_req,
	output logic [LANES-1:0] data_lock_req,
	output logic [LANES-1:0] lock_seen,
	output logic ready
);
	logic [1:0] st_r;
	logic [2:0] cnt_r;
	assign data_lock_req = {LANES{1'b0}};
	assign lock_seen = (lock_ref_req & ref_locked) | (~lock_ref_req & data_locked);
	assign ready = (st_r == 2'h0);
	// Mode is chosen on the third of the eight hold cycles, so the lane sees it settle before release.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= 2'h1;
			cnt_r <= 3'h0;
			analog_rst <= '1;
			digital_rst <= '1;
			lock_ref_req <= '0;
		end else begin
			case (st_r)
			2'h0: if (start) begin
				st_r <= 2'h1;
				cnt_r <= 3'h0;
				analog_rst <= '1;
				digital_rst <= '1;
			end
			2'h1: begin
				cnt_r <= cnt_r + 3'h1;
				if (cnt_r == 3'h2) lock_ref_req <= {LANES{os_need}};
				if (cnt_r == 3'h7) st_r <= 2'h2;
			end
			2'h2: if (cal_busy == 3'h0) begin
				analog_rst <= '0;
				st_r <= 2'h3;
			end
			default: if (&lock_seen) begin
				digital_rst <= '0;
				st_r <= 2'h0;
			end
			endcase
		end
	end
endmodule // hrx_ctl_model

// ### testbench/tb_hrx_cdr_top.sv
// Self-checking bench of the receive port with its reset and reconfiguration partner.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin bad_count++; \
	$display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module tb_hrx_cdr_top import hrx_pkg::*;;
	localparam int SPC = 2;
	logic clk = 0, rst_b = 0, link_clk = 0, reconfig_rst = 0, wr_en = 0, rd_en = 0, start = 0;
	logic ser_tog = 1, oversample_req, ready;
	logic [2:0] serial_in = 0;
	logic [2:0] dlr_drive = 0;
	logic [23:0] min_link = 24'h0952b8;
	logic [RCFG_REQ_W-1:0] rreq = '0;
	logic [RCFG_RSP_W-1:0] rsp;
	logic [3:0] addr = 0;
	logic [31:0] wr_data = 0, rd_data;
	logic [SPC*LANES*SYM_W-1:0] pdata;
	logic [2:0] ref_l, data_l, cal_busy, arst, drst, lreq, dreq, seen;
	int bad_count = 0, cmp_count = 0;
	always #10 clk = ~clk;
	always #7.5 link_clk = ~link_clk;
	always @(posedge link_clk) serial_in <= ser_tog ? ~serial_in : 3'h7;
	hrx_cdr_top #(.SPC(SPC)) hrx_cdr_top_i (.clk(clk), .rst_b(rst_b), .link_clk(link_clk),
		.analog_rst(arst), .digital_rst(drst), .lock_ref_req(lreq),
		.data_lock_req(dreq | dlr_drive),
		.serial_in(serial_in), .reconfig_rst(reconfig_rst), .reconfig_request_bus(rreq),
		.reconfig_response_bus(rsp), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .parallel_data(pdata), .cdr_reference_locked(ref_l),
		.cdr_data_locked(data_l), .cal_busy(cal_busy), .oversample_req(oversample_req));
	hrx_ctl_model hrx_ctl_model_i (.clk(clk), .rst_b(rst_b), .start(start),
		.os_need(oversample_req), .cal_busy(cal_busy), .ref_locked(ref_l),
		.data_locked(data_l), .analog_rst(arst), .digital_rst(drst), .lock_ref_req(lreq),
		.data_lock_req(dreq), .lock_seen(seen), .ready(ready));
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		d = rd_data;
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Write a rate by register or by the reconfiguration request and read back the plan.
	task automatic t_plan(input logic [23:0] rate, input logic [1:0] bpc, input logic bus);
		logic [31:0] tm, rf, lk, vd, v;
		logic os, hi, oor;
		os = rate < min_link;
		oor = rate > 24'h5b8d80;
		hi = rate >= 24'h33e140;
		tm = hi ? rate / 32'h28 : rate / 32'h0a;
		rf = os ? tm * 32'h5 : (hi ? tm * 32'h4 : tm);
		lk = (rate / 32'h0a) >> 1;
		vd = (bpc == 2'h0) ? lk : (bpc == 2'h1) ? lk * 32'h4 / 32'h5 :
			(bpc == 2'h2) ? lk * 32'h2 / 32'h3 : lk >> 1;
		wr(REG_CTRL, {30'h0, bpc});
		if (bus) begin
			@(posedge clk);
			rreq <= {1'b1, {(RCFG_REQ_W - 1 - RATE_W){1'b0}}, rate};
			@(posedge clk);
			rreq <= '0;
		end else wr(REG_BIT_RATE, {8'h0, rate});
		wait_clk(3);
		`CHK("oversample_req", os, oversample_req);
		rd(REG_PLAN, v);
		`CHK("plan", {28'h0, 1'b1, oor, os, hi}, v);
		rd(REG_TMDS, v);
		`CHK("tmds", tm, v);
		rd(REG_REFCLK, v);
		`CHK("refclk", rf, v);
		rd(REG_LINK, v);
		`CHK("link", lk, v);
		rd(REG_VIDEO, v);
		`CHK("video", vd, v);
		$display("test plan %0h done", rate);
	endtask
	// Restart the partner sequence and see the lane held while the resets stand.
	task automatic t_lane(input logic [23:0] rate, input logic refm);
		int i;
		logic ok;
		logic [31:0] v;
		wr(REG_BIT_RATE, {8'h0, rate});
		ser_tog = ~refm;
		@(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		wait_clk(3);
		`CHK("locks in reset", 6'h0, {ref_l, data_l});
		`CHK("word in reset", '0, pdata);
		for (i = 0; i < 3000 && ready !== 1'b1; i++) wait_clk(1);
		`CHK("ready", 1'b1, ready);
		wait_clk(200);
		`CHK("ref locked", {3{refm}}, ref_l);
		`CHK("data locked", {3{~refm}}, data_l);
		`CHK("rsp locks", {{3{~refm}}, {3{refm}}}, rsp[8:3]);
		ok = refm ? (pdata === '1) : (pdata === {3{20'h55555}} || pdata === {3{20'haaaaa}});
		`CHK("word", 1'b1, ok);
		rd(REG_LANE, v);
		`CHK("lane status", {17'h0, 3'h0, {3{refm}}, 3'h0, {3{~refm}}, {3{refm}}}, v);
		$display("test lane %0h done", rate);
	endtask
	// A stray data-lock request breaks the tie-off on purpose, to see it recorded.
	task automatic t_dlr();
		logic [31:0] v;
		@(posedge clk);
		dlr_drive <= 3'h5;
		@(posedge clk);
		dlr_drive <= 3'h0;
		rd(REG_LANE, v);
		`CHK("sticky request", 3'h5, v[14:12]);
		@(posedge clk);
		addr <= REG_LANE;
		wr_data <= {17'h0, 3'h7, 12'h0};
		wr_en <= 1'b1;
		dlr_drive <= 3'h1;
		@(posedge clk);
		wr_en <= 1'b0;
		dlr_drive <= 3'h0;
		rd(REG_LANE, v);
		`CHK("set beats clear", 3'h1, v[14:12]);
		wr(REG_LANE, {17'h0, 3'h1, 12'h0});
		rd(REG_LANE, v);
		`CHK("sticky cleared", 3'h0, v[14:12]);
		$display("test sticky request done");
	endtask
	initial begin
		#400000;
		bad_count++;
		print_verdict();
	end
	initial begin
		logic [31:0] v;
		logic [31:0] t0;
		repeat (5) @(posedge clk);
		#1;
		`CHK("cal in reset", 3'h7, cal_busy);
		@(posedge clk);
		rst_b <= 1'b1;
		rd(REG_BIT_RATE, v);
		`CHK("bit rate reset", {8'h0, BIT_RATE_RST}, v);
		rd(REG_MIN_LINK, v);
		`CHK("min link reset", {8'h0, MIN_LINK_RST}, v);
		wait_clk(480);
		`CHK("cal busy", 3'h7, cal_busy);
		wait_clk(20);
		`CHK("cal done", 3'h0, cal_busy);
		@(posedge clk);
		reconfig_rst <= 1'b1;
		wait_clk(3);
		`CHK("cal on reconfig reset", 3'h7, cal_busy);
		`CHK("rsp cal", 3'h7, rsp[2:0]);
		@(posedge clk);
		reconfig_rst <= 1'b0;
		wait_clk(490);
		`CHK("cal still busy", 3'h7, cal_busy);
		wait_clk(20);
		`CHK("cal after reconfig", 3'h0, cal_busy);
		`CHK("bus widths", 348, $bits(rreq) + $bits(rsp));
		`CHK("word width", SPC * 30, $bits(pdata));
		$display("test reset done");
		t_plan(24'h041eb0, 2'h0, 1'b0);
		t_plan(24'h05265c, 2'h1, 1'b1);
		t_plan(24'h062e08, 2'h2, 1'b0);
		t_plan(24'h083d60, 2'h3, 1'b1);
		t_plan(24'h0b5464, 2'h0, 1'b0);
		t_plan(24'h33e13f, 2'h0, 1'b1);
		t_plan(24'h33e140, 2'h0, 1'b0);
		t_plan(24'h5aa320, 2'h1, 1'b1);
		t_plan(24'h5b8d81, 2'h0, 1'b0);
		rd(REG_TMDS, t0);
		wr(REG_TMDS, 32'h1234);
		rd(REG_TMDS, v);
		`CHK("read only", t0, v);
		rd(4'hf, v);
		`CHK("unmapped", 32'h0, v);
		$display("test regs done");
		min_link = 24'h0f4240;
		wr(REG_MIN_LINK, {8'h0, min_link});
		rd(REG_MIN_LINK, v);
		`CHK("min link", {8'h0, min_link}, v);
		t_plan(24'h0b5464, 2'h0, 1'b1);
		min_link = 24'h0952b8;
		wr(REG_MIN_LINK, {8'h0, min_link});
		t_dlr();
		t_lane(24'h16a8c8, 1'b0);
		t_lane(24'h041eb0, 1'b1);
		print_verdict();
	end
endmodule // tb_hrx_cdr_top
